// File: epr_consts.svh
// Constants of the encoder pulse ratio core
`ifndef EPR_CONSTS_SVH
`define EPR_CONSTS_SVH
// ==========================================
// Timing
`define EPR_CLK_HZ 20000000
`define EPR_TICK_MS 1
`define EPR_MS_CYCLES ((`EPR_CLK_HZ / 1000) * `EPR_TICK_MS)
// ==========================================
// Ranges and reset values
`define EPR_RATIO_MIN 17'h00005
`define EPR_RATIO_MAX 17'h1869F
`define EPR_RATIO_DEF 17'h02710
`define EPR_GAP_MIN 17'h00001
`define EPR_GAP_MAX 17'h0C350
`define EPR_GAP_DEF 16'h03E8
`define EPR_BURST_MIN 17'h0000A
`define EPR_BURST_MAX 17'h00064
`define EPR_BURST_DEF 7'h14
`define EPR_REFR_MIN 17'h00032
`define EPR_REFR_MAX 17'h003E8
`define EPR_REFR_DEF 10'h0FA
`define EPR_SDIV_MIN 17'h00001
`define EPR_SDIV_MAX 17'h1869F
`define EPR_SDIV_DEF 17'h00064
`define EPR_SMUL_MIN 17'h00001
`define EPR_SMUL_MAX 17'h003E7
`define EPR_SMUL_DEF 10'h064
// ==========================================
// Codes and scale figures
`define EPR_TYPE_PULSE_BIT 2
`define EPR_CMD_RESET 4'h6
`define EPR_ZSEL_LOW_FIRST 4'h5
`define EPR_DEC4_SCALE 17'h02710
`define EPR_DEG_SCALE 17'h08CA0
`endif

// File: epr_pkg.sv
// Types of the encoder pulse ratio core
package epr_pkg;
  // ==========================================
  // Output quadrature phase, {a,b}, Gray order
  typedef enum logic [1:0] {
    EPR_PH0 = 2'h0,
    EPR_PH1 = 2'h2,
    EPR_PH2 = 2'h3,
    EPR_PH3 = 2'h1
  } epr_qphase_t;
  typedef enum logic [1:0] {
    EPR_RPT_DEC4 = 2'h0,
    EPR_RPT_WHOLE = 2'h1,
    EPR_RPT_DEG = 2'h2,
    EPR_RPT_USER = 2'h3
  } epr_rpt_mode_t;
  typedef enum logic [1:0] {
    EPR_OVF_LATCH = 2'h0,
    EPR_OVF_FOLLOW = 2'h1,
    EPR_OVF_OFF = 2'h2
  } epr_ovf_mode_t;
endpackage : epr_pkg

// File: epr_core.sv
// Encoder pulse ratio core: decode, scale, regenerate, lag report
// How it works
// - Output count is input times num over den.
// - Type codes 0-3 quadrature, 4-7 pulse/direction.
// - Pulse mode counts A rises, B gives direction.
// - Direction select swaps which channel leads forward.
// - One output marker per programmed impulse spacing.
// - Burst setting sizes the correction range.
// - Gate code zero disables marker referencing.
// - Codes 1-4 resync on marker with input high.
// - Codes 5-8 resync on marker with input low.
// - Gating input carries no command function.
// - Lag tracked and worked off every cycle.
// - Report refresh 50 to 1000 ms.
// - Modes 0-2: decimal, whole, degrees.
// - Mode 3: lag times multiplier over divisor.
// - Overflow mode 0 latches until reset command.
// - Overflow mode 1 follows the condition.
// - Overflow mode 2 never flags.
// - Command code 6 issues reset, clears overflow.
`include "epr_consts.svh"
module epr_core #(
  parameter int unsigned MS_CYCLES = `EPR_MS_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_enc_a,
  input wire logic i_enc_b,
  input wire logic i_enc_z,
  input wire logic [3:0] i_ctrl,
  input wire logic i_cfg_load,
  input wire logic [19:0] i_password,
  input wire logic [19:0] i_prot_factor,
  input wire logic [19:0] i_prot_general,
  input wire logic [19:0] i_prot_report,
  input wire logic [19:0] i_prot_command,
  input wire logic [16:0] i_ratio_num,
  input wire logic [16:0] i_ratio_den,
  input wire logic [2:0] i_enc_type,
  input wire logic i_dir_sel,
  input wire logic [15:0] i_marker_gap,
  input wire logic [6:0] i_burst,
  input wire logic [3:0] i_zgate_sel,
  input wire logic [3:0] i_ctrl_func1,
  input wire logic [3:0] i_ctrl_func2,
  input wire logic [3:0] i_ctrl_func3,
  input wire logic [3:0] i_ctrl_func4,
  input wire logic [9:0] i_refresh_ms,
  input wire logic [1:0] i_report_mode,
  input wire logic [16:0] i_scale_div,
  input wire logic [9:0] i_scale_mul,
  input wire logic [1:0] i_ovf_mode,
  output logic o_out_a,
  output logic o_out_b,
  output logic o_out_z,
  output logic signed [31:0] o_lag,
  output logic signed [31:0] o_report,
  output logic o_report_stb,
  output logic o_overflow,
  output logic o_cfg_refused
);
  // ==========================================
  // Functions
  function automatic logic [16:0] clampv(input logic [16:0] v, input logic [16:0] lo,
                                         input logic [16:0] hi);
    clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
  function automatic logic unlocked(input logic [19:0] prot, input logic [19:0] pw);
    unlocked = (prot == 20'h00000) || (prot == pw);
  endfunction
  function automatic logic [31:0] mag32(input logic signed [31:0] v);
    mag32 = v[31] ? 32'(-v) : 32'(v);
  endfunction
  function automatic logic signed [31:0] scale(input logic signed [31:0] v,
                                               input logic [16:0] mul, input logic [16:0] div);
    logic [48:0] p;
    logic [48:0] q;
    p = 49'(mag32(v)) * 49'(mul);
    q = p / 49'(div);
    scale = v[31] ? -$signed(q[31:0]) : $signed(q[31:0]);
  endfunction
  function automatic logic [1:0] quad_step(input logic [1:0] p, input logic [1:0] c);
    case ({p, c})
      4'h1, 4'h7, 4'hE, 4'h8: quad_step = 2'h3;
      4'h2, 4'hB, 4'hD, 4'h4: quad_step = 2'h2;
      default: quad_step = 2'h0;
    endcase
  endfunction
  function automatic epr_pkg::epr_qphase_t phase_step(input epr_pkg::epr_qphase_t ph,
                                                       input logic up);
    case (ph)
      epr_pkg::EPR_PH0: phase_step = up ? epr_pkg::EPR_PH1 : epr_pkg::EPR_PH3;
      epr_pkg::EPR_PH1: phase_step = up ? epr_pkg::EPR_PH2 : epr_pkg::EPR_PH0;
      epr_pkg::EPR_PH2: phase_step = up ? epr_pkg::EPR_PH3 : epr_pkg::EPR_PH1;
      default: phase_step = up ? epr_pkg::EPR_PH0 : epr_pkg::EPR_PH2;
    endcase
  endfunction
  // ==========================================
  // Pin synchronisers {ctrl, z, b, a}
  logic [6:0] sync1_q, sync2_q, prev_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
      prev_q <= 7'h00;
    end else begin
      sync1_q <= {i_ctrl, i_enc_z, i_enc_b, i_enc_a};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  // ==========================================
  // Configuration groups
  logic [16:0] num_q, num_d, den_q, den_d, sdiv_q, sdiv_d;
  logic [2:0] type_q, type_d;
  logic dir_q, dir_d, refused_q, refused_d, ld_general;
  logic [15:0] gap_q, gap_d;
  logic [6:0] burst_q, burst_d;
  logic [3:0] zsel_q, zsel_d;
  logic [3:0] func_q [4];
  logic [3:0] func_d [4];
  logic [9:0] refr_q, refr_d, smul_q, smul_d;
  epr_pkg::epr_rpt_mode_t rmode_q, rmode_d;
  epr_pkg::epr_ovf_mode_t ovfm_q, ovfm_d;
  always_comb begin
    num_d = num_q;
    den_d = den_q;
    type_d = type_q;
    dir_d = dir_q;
    gap_d = gap_q;
    burst_d = burst_q;
    zsel_d = zsel_q;
    func_d = func_q;
    refr_d = refr_q;
    rmode_d = rmode_q;
    sdiv_d = sdiv_q;
    smul_d = smul_q;
    ovfm_d = ovfm_q;
    refused_d = refused_q;
    ld_general = 1'b0;
    if (i_cfg_load) begin
      refused_d = 1'b0;
      if (unlocked(i_prot_factor, i_password)) begin
        num_d = clampv(i_ratio_num, `EPR_RATIO_MIN, `EPR_RATIO_MAX);
        den_d = clampv(i_ratio_den, `EPR_RATIO_MIN, `EPR_RATIO_MAX);
      end else begin
        refused_d = 1'b1;
      end
      if (unlocked(i_prot_general, i_password)) begin
        ld_general = 1'b1;
        type_d = i_enc_type;
        dir_d = i_dir_sel;
        gap_d = 16'(clampv({1'b0, i_marker_gap}, `EPR_GAP_MIN, `EPR_GAP_MAX));
        burst_d = 7'(clampv({10'h000, i_burst}, `EPR_BURST_MIN, `EPR_BURST_MAX));
        zsel_d = (i_zgate_sel > 4'h8) ? 4'h0 : i_zgate_sel;
      end else begin
        refused_d = 1'b1;
      end
      if (unlocked(i_prot_report, i_password)) begin
        refr_d = 10'(clampv({7'h00, i_refresh_ms}, `EPR_REFR_MIN, `EPR_REFR_MAX));
        rmode_d = epr_pkg::epr_rpt_mode_t'(i_report_mode);
        sdiv_d = clampv(i_scale_div, `EPR_SDIV_MIN, `EPR_SDIV_MAX);
        smul_d = 10'(clampv({7'h00, i_scale_mul}, `EPR_SMUL_MIN, `EPR_SMUL_MAX));
        ovfm_d = (i_ovf_mode > 2'h2) ? epr_pkg::EPR_OVF_OFF : epr_pkg::epr_ovf_mode_t'(i_ovf_mode);
      end else begin
        refused_d = 1'b1;
      end
      if (unlocked(i_prot_command, i_password)) begin
        func_d[0] = (i_ctrl_func1 > 4'h9) ? 4'h0 : i_ctrl_func1;
        func_d[1] = (i_ctrl_func2 > 4'h9) ? 4'h0 : i_ctrl_func2;
        func_d[2] = (i_ctrl_func3 > 4'h9) ? 4'h0 : i_ctrl_func3;
        func_d[3] = (i_ctrl_func4 > 4'h9) ? 4'h0 : i_ctrl_func4;
      end else begin
        refused_d = 1'b1;
      end
      if (zsel_d != 4'h0) begin
        func_d[2'(zsel_d - 4'h1)] = 4'h0;
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      num_q <= `EPR_RATIO_DEF;
      den_q <= `EPR_RATIO_DEF;
      type_q <= 3'h0;
      dir_q <= 1'b0;
      gap_q <= `EPR_GAP_DEF;
      burst_q <= `EPR_BURST_DEF;
      zsel_q <= 4'h0;
      func_q <= '{4'h0, 4'h0, 4'h0, 4'h0};
      refr_q <= `EPR_REFR_DEF;
      rmode_q <= epr_pkg::EPR_RPT_DEC4;
      sdiv_q <= `EPR_SDIV_DEF;
      smul_q <= `EPR_SMUL_DEF;
      ovfm_q <= epr_pkg::EPR_OVF_LATCH;
      refused_q <= 1'b0;
    end else begin
      num_q <= num_d;
      den_q <= den_d;
      type_q <= type_d;
      dir_q <= dir_d;
      gap_q <= gap_d;
      burst_q <= burst_d;
      zsel_q <= zsel_d;
      func_q <= func_d;
      refr_q <= refr_d;
      rmode_q <= rmode_d;
      sdiv_q <= sdiv_d;
      smul_q <= smul_d;
      ovfm_q <= ovfm_d;
      refused_q <= refused_d;
    end
  end
  // ==========================================
  // Ratio engine, output generator, marker, overflow
  logic ev_valid, ev_up, zhit, rst_cmd, ovf_cond, z_d, z_q, ovf_d, ovf_q;
  logic [1:0] qs;
  logic [3:0] ctrl_rise;
  logic signed [39:0] acc_q, acc_d, numx, denx;
  logic signed [31:0] lag_q, lag_d;
  logic [15:0] mark_q, mark_d;
  epr_pkg::epr_qphase_t phase_q, phase_d;
  always_comb begin
    qs = quad_step(prev_q[1:0], sync2_q[1:0]);
    if (type_q[`EPR_TYPE_PULSE_BIT]) begin
      ev_valid = sync2_q[0] & ~prev_q[0];
      ev_up = sync2_q[1];
    end else begin
      ev_valid = qs[1];
      ev_up = qs[0] ^ dir_q;
    end
    numx = $signed({23'h000000, num_q});
    denx = $signed({23'h000000, den_q});
    acc_d = acc_q;
    lag_d = lag_q;
    // Whole output steps move to the lag at once, so the lag shows the backlog
    if (acc_q >= denx || acc_q <= -denx) begin
      acc_d = acc_q % denx;
      lag_d = lag_q + 32'(acc_q / denx);
    end
    if (ev_valid) begin
      acc_d = ev_up ? acc_d + numx : acc_d - numx;
    end
    phase_d = phase_q;
    mark_d = mark_q;
    z_d = 1'b0;
    if (lag_q != 32'sh0) begin
      phase_d = phase_step(phase_q, ~lag_q[31]);
      lag_d = lag_q[31] ? lag_d + 32'sh1 : lag_d - 32'sh1;
      if (!lag_q[31]) begin
        z_d = (mark_q == gap_q - 16'h1);
        mark_d = z_d ? 16'h0000 : mark_q + 16'h1;
      end else begin
        z_d = (mark_q == 16'h0000);
        mark_d = z_d ? gap_q - 16'h1 : mark_q - 16'h1;
      end
    end
    ctrl_rise = sync2_q[6:3] & ~prev_q[6:3];
    zhit = 1'b0;
    if (sync2_q[2] && !prev_q[2] && zsel_q != 4'h0) begin
      if (zsel_q < `EPR_ZSEL_LOW_FIRST) begin
        zhit = sync2_q[3 + 32'(2'(zsel_q - 4'h1))];
      end else begin
        zhit = ~sync2_q[3 + 32'(2'(zsel_q - 4'h1))];
      end
    end
    if (zhit || ld_general) begin
      mark_d = 16'h0000;
    end
    rst_cmd = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (func_q[i] == `EPR_CMD_RESET && ctrl_rise[i] &&
          !(zsel_q != 4'h0 && 2'(zsel_q - 4'h1) == 2'(i))) begin
        rst_cmd = 1'b1;
      end
    end
    ovf_cond = mag32(lag_q) > {25'h0000000, burst_q};
    case (ovfm_q)
      epr_pkg::EPR_OVF_LATCH: ovf_d = ovf_cond | (ovf_q & ~rst_cmd);
      epr_pkg::EPR_OVF_FOLLOW: ovf_d = ovf_cond;
      default: ovf_d = 1'b0;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_q <= 40'sh0;
      lag_q <= 32'sh0;
      phase_q <= epr_pkg::EPR_PH0;
      mark_q <= 16'h0000;
      z_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      lag_q <= lag_d;
      phase_q <= phase_d;
      mark_q <= mark_d;
      z_q <= z_d;
      ovf_q <= ovf_d;
    end
  end
  // ==========================================
  // Lag report refresh
  logic [15:0] ms_q, ms_d;
  logic [9:0] rms_q, rms_d;
  logic signed [31:0] rpt_q, rpt_d;
  logic stb_q, stb_d;
  logic [16:0] rmul, rdiv;
  always_comb begin
    case (rmode_q)
      epr_pkg::EPR_RPT_DEC4: begin
        rmul = `EPR_DEC4_SCALE;
        rdiv = 17'h00001;
      end
      epr_pkg::EPR_RPT_WHOLE: begin
        rmul = 17'h00001;
        rdiv = 17'h00001;
      end
      epr_pkg::EPR_RPT_DEG: begin
        rmul = `EPR_DEG_SCALE;
        rdiv = sdiv_q;
      end
      default: begin
        rmul = {7'h00, smul_q};
        rdiv = sdiv_q;
      end
    endcase
    ms_d = ms_q + 16'h1;
    rms_d = rms_q;
    rpt_d = rpt_q;
    stb_d = 1'b0;
    if (ms_q == 16'(MS_CYCLES - 1)) begin
      ms_d = 16'h0000;
      rms_d = rms_q + 10'h001;
      if (rms_q + 10'h001 >= refr_q) begin
        rms_d = 10'h000;
        stb_d = 1'b1;
        rpt_d = scale(lag_q, rmul, rdiv);
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ms_q <= 16'h0000;
      rms_q <= 10'h000;
      rpt_q <= 32'sh0;
      stb_q <= 1'b0;
    end else begin
      ms_q <= ms_d;
      rms_q <= rms_d;
      rpt_q <= rpt_d;
      stb_q <= stb_d;
    end
  end
  assign o_out_a = phase_q[1];
  assign o_out_b = phase_q[0];
  assign o_out_z = z_q;
  assign o_lag = lag_q;
  assign o_report = rpt_q;
  assign o_report_stb = stb_q;
  assign o_overflow = ovf_q;
  assign o_cfg_refused = refused_q;
  // ==========================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  property p_ratio_gen;
    (acc_q >= denx && lag_q == 32'sh0) |=> lag_q == 32'($past(acc_q / denx));
  endproperty
  a_ratio_gen: assert property (p_ratio_gen) else $error("lag not raised");
  property p_pulse_dir;
    (type_q[2] && sync2_q[0] && !prev_q[0]) |-> (ev_valid && ev_up == sync2_q[1]);
  endproperty
  a_pulse_dir: assert property (p_pulse_dir) else $error("pulse event wrong");
  property p_gap; mark_q < gap_q; endproperty
  a_gap: assert property (p_gap) else $error("marker count out of range");
  property p_resync; zhit |=> mark_q == 16'h0000; endproperty
  a_resync: assert property (p_resync) else $error("marker not resynced");
  property p_drain; (lag_q != 32'sh0) |=> phase_q != $past(phase_q); endproperty
  a_drain: assert property (p_drain) else $error("lag not worked off");
  property p_ovf_hold;
    (ovfm_q == epr_pkg::EPR_OVF_LATCH && ovf_q && !rst_cmd && !i_cfg_load) |=> ovf_q;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("latched overflow lost");
  property p_ovf_follow;
    (ovfm_q == epr_pkg::EPR_OVF_FOLLOW && $past(ovfm_q) == epr_pkg::EPR_OVF_FOLLOW)
      |-> ovf_q == $past(ovf_cond);
  endproperty
  a_ovf_follow: assert property (p_ovf_follow) else $error("overflow not following");
  property p_ovf_off;
    (ovfm_q == epr_pkg::EPR_OVF_OFF && $past(ovfm_q) == epr_pkg::EPR_OVF_OFF) |-> !ovf_q;
  endproperty
  a_ovf_off: assert property (p_ovf_off) else $error("overflow raised when off");
  property p_ovf_set; (ovf_cond && ovfm_q != epr_pkg::EPR_OVF_OFF && !i_cfg_load) |=> ovf_q;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");
  c_marker: cover property (z_q);
  c_resync: cover property (zhit);
  c_overflow: cover property (ovf_q && rst_cmd);
  c_report: cover property (stb_q && rpt_q != 32'sh0);
endmodule // epr_core

// File: epr_enc_model.sv
// Encoder model: quadrature, pulse/direction and marker
module epr_enc_model (
  input wire logic i_clk,
  output logic o_a,
  output logic o_b,
  output logic o_z
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_a = 1'b0;
    o_b = 1'b0;
    o_z = 1'b0;
  end

  // ==========================================
  // Quadrature step, A leads B when forward
  task automatic quad(input logic fwd, input int gap);
    logic [1:0] idx;
    idx = {o_b, o_a ^ o_b};
    idx = fwd ? idx + 2'h1 : idx - 2'h1;
    @(posedge i_clk);
    #1;
    o_b = idx[1];
    o_a = idx[1] ^ idx[0];
    repeat (gap) @(posedge i_clk);
  endtask

  // ==========================================
  // Pulse on A, direction level on B
  task automatic pulse(input logic dir, input int gap);
    @(posedge i_clk);
    #1;
    o_a = 1'b0;
    o_b = dir;
    repeat (gap) @(posedge i_clk);
    #1;
    o_a = 1'b1;
    repeat (gap) @(posedge i_clk);
  endtask

  // ==========================================
  // Marker pulse
  task automatic marker(input int gap);
    @(posedge i_clk);
    #1;
    o_z = 1'b1;
    repeat (gap) @(posedge i_clk);
    #1;
    o_z = 1'b0;
    repeat (gap) @(posedge i_clk);
  endtask
endmodule // epr_enc_model

// File: epr_core_tb.sv
// Testbench of the encoder pulse ratio core
`include "epr_consts.svh"
module epr_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_resetn, i_cfg_load, i_dir_sel, i_enc_a, i_enc_b, i_enc_z;
  logic [3:0] i_ctrl, i_zgate_sel, i_ctrl_func1, i_ctrl_func2, i_ctrl_func3, i_ctrl_func4;
  logic [19:0] i_password, i_prot_factor, i_prot_general, i_prot_report, i_prot_command;
  logic [16:0] i_ratio_num, i_ratio_den, i_scale_div;
  logic [2:0] i_enc_type;
  logic [15:0] i_marker_gap;
  logic [6:0] i_burst;
  logic [9:0] i_refresh_ms, i_scale_mul;
  logic [1:0] i_report_mode, i_ovf_mode;
  logic o_out_a, o_out_b, o_out_z, o_report_stb, o_overflow, o_cfg_refused;
  logic signed [31:0] o_lag, o_report;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int net = 0;
  int nz = 0;
  int n, t;
  logic [1:0] pq = 2'h0;
  logic [1:0] d;
  logic [1:0] ovf_chk = 2'h0;
  logic cond, cond_q, seen;
  logic ovf_exp;
  int lag_prev = 0;
  logic [1:0] rm_eff = 2'h0;
  logic [1:0] rm_next = 2'h0;
  logic [16:0] tn [4] = '{17'h01388, 17'h02710, 17'h04E20, 17'h02710};
  logic [16:0] td [4] = '{17'h02710, 17'h09C40, 17'h02710, 17'h02710};
  int te [4] = '{2, 1, 8, 4};

  always #25 i_clk = ~i_clk;

  epr_core #(.MS_CYCLES(20)) u_epr_core (
    .i_clk, .i_resetn, .i_enc_a, .i_enc_b, .i_enc_z, .i_ctrl, .i_cfg_load, .i_password,
    .i_prot_factor, .i_prot_general, .i_prot_report, .i_prot_command, .i_ratio_num,
    .i_ratio_den, .i_enc_type, .i_dir_sel, .i_marker_gap, .i_burst, .i_zgate_sel,
    .i_ctrl_func1, .i_ctrl_func2, .i_ctrl_func3, .i_ctrl_func4, .i_refresh_ms,
    .i_report_mode, .i_scale_div, .i_scale_mul, .i_ovf_mode, .o_out_a, .o_out_b, .o_out_z,
    .o_lag, .o_report, .o_report_stb, .o_overflow, .o_cfg_refused
  );

  epr_enc_model u_epr_enc_model (.i_clk, .o_a(i_enc_a), .o_b(i_enc_b), .o_z(i_enc_z));

  // ==========================================
  // Output monitor and cycle limit
  always @(negedge i_clk) begin
    d = {o_out_b, o_out_a ^ o_out_b} - pq;
    pq = {o_out_b, o_out_a ^ o_out_b};
    if (d == 2'h1) net++;
    else if (d == 2'h3) net--;
    if (o_out_z === 1'b1) nz++;
    ovf_exp = ovf_chk == 2'h1 && cond_q;
    if (ovf_chk != 2'h0) chk("overflow", {31'h0, o_overflow}, {31'h0, ovf_exp});
    if (o_report_stb === 1'b1) chk("report", o_report, exp_rpt(lag_prev, rm_eff));
    lag_prev = o_lag;
    rm_eff = rm_next;
    if (i_cfg_load === 1'b1) rm_next = i_report_mode;
    cond = (o_lag > $signed({25'h0, i_burst})) || (o_lag < -$signed({25'h0, i_burst}));
    if (cond) seen = 1'b1;
    cond_q = cond;
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      results();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic chk(input string nm, input logic signed [31:0] sv, input logic signed [31:0] ev);
    n_compared++;
    if (sv !== ev) begin
      err_total++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, ev, sv);
    end
  endtask

  function automatic int exp_rpt(input int lag, input logic [1:0] m);
    case (m)
      2'h0: exp_rpt = lag * int'(`EPR_DEC4_SCALE);
      2'h1: exp_rpt = lag;
      2'h2: exp_rpt = lag * int'(`EPR_DEG_SCALE) / int'(i_scale_div);
      default: exp_rpt = lag * int'(i_scale_mul) / int'(i_scale_div);
    endcase
  endfunction

  task automatic results();
    $display("Mismatches %0d of %0d compared", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic load();
    @(posedge i_clk);
    #1 i_cfg_load = 1'b1;
    @(posedge i_clk);
    #1 i_cfg_load = 1'b0;
  endtask

  task automatic settle();
    n = 0;
    repeat (8) @(posedge i_clk);
    while (o_lag !== 32'h0 && n < 2000) begin
      @(posedge i_clk);
      n++;
    end
    repeat (4) @(posedge i_clk);
    #1;
  endtask

  task automatic steps(input logic fwd, input int cnt, input int gap);
    repeat (cnt) u_epr_enc_model.quad(fwd, gap);
    settle();
  endtask

  task automatic wait_stb();
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (o_report_stb !== 1'b1 && n < 8000);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    i_resetn = 1'b0;
    i_cfg_load = 1'b0;
    i_ctrl = 4'h0;
    i_password = 20'h0;
    i_prot_factor = 20'h0;
    i_prot_general = 20'h0;
    i_prot_report = 20'h0;
    i_prot_command = 20'h0;
    i_ratio_num = `EPR_RATIO_DEF;
    i_ratio_den = `EPR_RATIO_DEF;
    i_enc_type = 3'h0;
    i_dir_sel = 1'b0;
    i_marker_gap = `EPR_GAP_DEF;
    i_burst = `EPR_BURST_DEF;
    i_zgate_sel = 4'h0;
    i_ctrl_func1 = 4'h0;
    i_ctrl_func2 = 4'h0;
    i_ctrl_func3 = 4'h0;
    i_ctrl_func4 = 4'h0;
    i_refresh_ms = `EPR_REFR_DEF;
    i_report_mode = 2'h0;
    i_scale_div = `EPR_SDIV_DEF;
    i_scale_mul = `EPR_SMUL_DEF;
    i_ovf_mode = 2'h0;
    repeat (10) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    chk("lag", o_lag, 32'h0);
    chk("pins", {27'h0, o_out_a, o_out_b, o_out_z, o_overflow, o_cfg_refused}, 32'h0);
    for (t = 0; t < 8; t++) begin
      i_enc_type = t[2:0];
      load();
      settle();
      net = 0;
      if (t < 4) repeat (4) u_epr_enc_model.quad(1'b1, 3);
      else begin
        repeat (3) u_epr_enc_model.pulse(1'b1, 3);
        u_epr_enc_model.pulse(1'b0, 3);
      end
      settle();
      chk("type count", net, t < 4 ? 4 : 2);
    end
    i_enc_type = 3'h0;
    i_dir_sel = 1'b1;
    load();
    settle();
    net = 0;
    steps(1'b1, 4, 3);
    steps(1'b0, 2, 3);
    chk("reversed", net, 32'hFFFF_FFFE);
    i_dir_sel = 1'b0;
    for (t = 0; t < 4; t++) begin
      i_ratio_num = tn[t];
      i_ratio_den = td[t];
      load();
      settle();
      net = 0;
      steps(1'b1, 4, 3);
      chk("scaled", net, te[t]);
    end
    i_prot_factor = 20'h0007B;
    i_prot_general = 20'h0007B;
    i_prot_report = 20'h0007B;
    i_prot_command = 20'h0007B;
    i_ratio_num = 17'h04E20;
    load();
    chk("refused", {31'h0, o_cfg_refused}, 32'h1);
    net = 0;
    steps(1'b1, 4, 3);
    chk("locked ratio", net, 4);
    i_password = 20'h0007B;
    load();
    chk("refused", {31'h0, o_cfg_refused}, 32'h0);
    i_ratio_num = 17'h02710;
    i_marker_gap = 16'h0004;
    load();
    settle();
    nz = 0;
    steps(1'b1, 8, 3);
    chk("markers", nz, 2);
    nz = 0;
    steps(1'b0, 4, 3);
    chk("markers back", nz, 1);
    for (t = 0; t < 2; t++) begin
      i_zgate_sel = (t != 0) ? 4'h5 : 4'h1;
      i_ctrl = (t != 0) ? 4'h0 : 4'h1;
      load();
      settle();
      repeat (2) u_epr_enc_model.quad(1'b1, 3);
      u_epr_enc_model.marker(3);
      settle();
      nz = 0;
      steps(1'b1, 3, 3);
      chk("resync", nz, 0);
      steps(1'b1, 1, 3);
      chk("resync", nz, 1);
    end
    i_zgate_sel = 4'h0;
    i_ctrl = 4'h0;
    i_burst = 7'h0A;
    i_ratio_den = 17'h00064;
    load();
    settle();
    seen = 1'b0;
    steps(1'b1, 10, 2);
    chk("latched", {31'h0, o_overflow}, 32'h1);
    chk("lag over burst", {31'h0, seen}, 32'h1);
    i_ctrl_func1 = 4'h6;
    i_ctrl_func2 = 4'h6;
    i_ctrl_func3 = 4'h6;
    i_ctrl_func4 = 4'h6;
    load();
    i_ctrl = 4'hF;
    repeat (6) @(posedge i_clk);
    #1 chk("cleared", {31'h0, o_overflow}, 32'h0);
    i_ctrl = 4'h0;
    for (t = 1; t < 3; t++) begin
      i_ovf_mode = t[1:0];
      load();
      repeat (3) @(posedge i_clk);
      #1 ovf_chk = t[1:0];
      steps(1'b1, 10, 2);
      ovf_chk = 2'h0;
    end
    for (t = 0; t < 4; t++) begin
      i_report_mode = t[1:0];
      i_refresh_ms = 10'h032;
      i_scale_div = 17'h00007;
      i_scale_mul = 10'h003;
      load();
      fork
        begin
          wait_stb();
          chk("report strobe", {31'h0, o_report_stb}, 32'h1);
        end
        repeat (12) u_epr_enc_model.quad(1'b1, 2);
      join
      settle();
    end
    wait_stb();
    wait_stb();
    chk("refresh", n, 1000);
    results();
  end
endmodule // epr_core_tb
